// ==== design/bicr_cfg.svh ====
// holds the offset, field positions, reset value and timing figures
// of the bus interface control register block.
// assumes it is included by its bare name from the package and modules.
`ifndef BICR_CFG_SVH
`define BICR_CFG_SVH

// ----------------------------------------------------------------
// register number on the control coprocessor port
// ----------------------------------------------------------------
`define BICR_REG_NUM       5'h02

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BICR_LOCK_BIT      31
`define BICR_RES_HIGH_BIT  29
`define BICR_BR_IN_BIT     19
`define BICR_IO_HI         15
`define BICR_IO_LO         14
`define BICR_EXT_HI        13
`define BICR_EXT_LO        12
`define BICR_MEM_HI        11
`define BICR_MEM_LO        10
`define BICR_TC_HOLD_BIT   8
`define BICR_DMA_BIT       7
`define BICR_BE16_BIT      5
`define BICR_BE_BIT        4
`define BICR_TURN_HI       1
`define BICR_TURN_LO       0

// ----------------------------------------------------------------
// reset value, writable bits, forced-high bit
// ----------------------------------------------------------------
`define BICR_RESET_VAL     32'h2008_f433
`define BICR_WR_MASK       32'h8008_fdb3
`define BICR_RES_HIGH_VAL  32'h2000_0000

// ----------------------------------------------------------------
// timing figures in clock cycles
// ----------------------------------------------------------------
`define BICR_TC_DELAY_CYC  2
`define BICR_TC_PULSE_CYC  2

`endif

// ==== design/bicr_pkg.sv ====
// types shared by the bus interface control register block.
// assumes bicr_cfg.svh sits in the include path.
`include "bicr_cfg.svh"

package bicr_pkg;

    // ------------------------------------------------------------
    // decoded control fields
    // ------------------------------------------------------------
    typedef struct packed {
        logic       lock;       // write lock
        logic       br_in;      // shared pins are inputs
        logic [1:0] io_mode;    // io strobe use
        logic [1:0] ext_mode;   // buffer enable use
        logic [1:0] mem_mode;   // memory strobe use
        logic       tc_hold;    // terminal count held
        logic       dma_pulse;  // dma pulse protocol
        logic       be16_rd;    // halfword lanes on reads
        logic       be_rd;      // byte lanes on reads
        logic [1:0] turn;       // extra turnaround cycles
    } bicr_ctl_t;

    // ------------------------------------------------------------
    // strobe phase of the current bus cycle
    // ------------------------------------------------------------
    typedef struct packed {
        logic       rd;         // read strobe phase
        logic       wr;         // write strobe phase
        logic [3:0] byte_sel;   // wanted byte lanes
        logic [1:0] half_sel;   // wanted halfword lanes
    } bicr_cyc_t;

    // dma arbitration state
    typedef enum logic [1:0] {
        BICR_DMA_IDLE,
        BICR_DMA_GRANT,
        BICR_DMA_RECLAIM
    } bicr_dma_st_t;

    // split the raw register word into its fields
    function automatic bicr_ctl_t bicr_decode(input logic [31:0] r);
        bicr_ctl_t c;
        c.lock      = r[`BICR_LOCK_BIT];
        c.br_in     = r[`BICR_BR_IN_BIT];
        c.io_mode   = r[`BICR_IO_HI:`BICR_IO_LO];
        c.ext_mode  = r[`BICR_EXT_HI:`BICR_EXT_LO];
        c.mem_mode  = r[`BICR_MEM_HI:`BICR_MEM_LO];
        c.tc_hold   = r[`BICR_TC_HOLD_BIT];
        c.dma_pulse = r[`BICR_DMA_BIT];
        c.be16_rd   = r[`BICR_BE16_BIT];
        c.be_rd     = r[`BICR_BE_BIT];
        c.turn      = r[`BICR_TURN_HI:`BICR_TURN_LO];
        return c;
    endfunction

endpackage

// ==== design/bicr_tc_gen.sv ====
// terminal count waveform generator.
// assumes match_i is a one-cycle pulse from the timer on the same clock.
`timescale 1ns/1ps
`include "bicr_cfg.svh"

module bicr_tc_gen
    import bicr_pkg::*;
(
    input  wire logic core_clk_i,   // system clock
    input  wire logic rst_n_i,      // async reset, active low
    input  wire logic ce_i,         // clock enable
    input  wire logic match_i,      // count equals compare
    input  wire logic cmp_wr_i,     // compare register rewritten
    input  wire logic hold_mode_i,  // hold until compare rewrite
    output logic      tc_n_o        // terminal count, active low
);

    logic       dly_ff;     // match delayed one cycle
    logic       on_ff;      // output asserted
    logic       left_ff;    // pulse has one more cycle
    logic       nxt_dly;
    logic       nxt_on;
    logic       nxt_left;
    logic       tc_n_ff;    // output pin level, active low
    logic       nxt_tc_n;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_dly  = match_i;
        nxt_on   = on_ff;
        nxt_left = left_ff;
        if (dly_ff) begin
            nxt_on   = 1'b1;
            nxt_left = 1'b1;
        end else if (on_ff && hold_mode_i) begin
            nxt_on = ~cmp_wr_i;
        end else if (on_ff) begin
            nxt_on   = left_ff;
            nxt_left = 1'b0;
        end
        // pin level kept in its own flop, no gate after it
        nxt_tc_n = ~nxt_on;
    end

    // registers; a fresh match beats a compare rewrite
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dly_ff  <= 1'b0;
            on_ff   <= 1'b0;
            left_ff <= 1'b0;
            tc_n_ff <= 1'b1;
        end else if (ce_i) begin
            dly_ff  <= nxt_dly;
            on_ff   <= nxt_on;
            left_ff <= nxt_left;
            tc_n_ff <= nxt_tc_n;
        end
    end

    assign tc_n_o = tc_n_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_match_seen;
        match_i && ce_i ##1 ce_i;
    endsequence

    property p_tc_assert;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_match_seen |=> !tc_n_o;
    endproperty
    a_tc_assert: assert property (p_tc_assert)
        else $error("terminal count late after match");

    property p_tc_pulse;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        ($fell(tc_n_o) && !hold_mode_i && !dly_ff && ce_i ##1
         ce_i && !hold_mode_i && !dly_ff) |=> tc_n_o;
    endproperty
    a_tc_pulse: assert property (p_tc_pulse)
        else $error("pulse mode terminal count did not negate");

    property p_tc_hold;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!tc_n_o && hold_mode_i && !cmp_wr_i) |=> !tc_n_o;
    endproperty
    a_tc_hold: assert property (p_tc_hold)
        else $error("hold mode terminal count dropped early");

endmodule

// ==== design/bicr_top.sv ====
// bus interface control register with its pin shaping logic.
// assumes the core bus cycle logic, timer and coprocessor move port run
// on core_clk_i; bus request and shared branch pins come from outside.
`timescale 1ns/1ps
`include "bicr_cfg.svh"

module bicr_top
    import bicr_pkg::*;
(
    input  wire logic        core_clk_i,        // 25 MHz system clock
    input  wire logic        rst_n_i,           // async reset, low
    input  wire logic        ce_i,              // clock enable
    // coprocessor register port
    input  wire logic        cp0_wr_i,          // move-to strobe
    input  wire logic [4:0]  cp0_wr_sel_i,      // target register
    input  wire logic [31:0] cp0_wr_data_i,     // write data
    input  wire logic        cp0_rd_i,          // move-from strobe
    input  wire logic [4:0]  cp0_rd_sel_i,      // source register
    output logic      [31:0] cp0_rd_data_o,     // read data
    output logic             cp0_rd_hit_o,      // read was ours
    // bus cycle side
    input  wire bicr_cyc_t   cyc_i,             // current strobe phase
    input  wire logic        rd_sampled_i,      // read data taken
    output logic             turnaround_hold_o, // no new address yet
    // strobe and lane pins, active low
    output logic             memory_access_strobe_n_o,
    output logic [3:0]       byte_lane_selects_n_o,
    output logic [1:0]       halfword_lane_selects_n_o,
    // shared branch condition pins, [1] upper, [0] lower
    input  wire logic [1:0]  shared_branch_condition_pins_i,
    output logic      [1:0]  shared_branch_condition_pins_o,
    output logic      [1:0]  shared_branch_condition_pins_oe_o,
    output logic      [1:0]  branch_condition_sync_o,
    // dma arbitration
    input  wire logic        bus_request_in_n_i,  // pin, active low
    input  wire logic        reclaim_req_i,       // core wants bus
    output logic             bus_grant_out_n_o,   // pin, active low
    // timer
    input  wire logic        count_match_i,     // count equals compare
    input  wire logic        compare_wr_i,      // compare rewritten
    output logic             terminal_count_out_n_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [31:0]  ctl_ff, nxt_ctl;            // raw register word
    bicr_ctl_t    ctl;                        // decoded fields
    logic         wr_hit;                     // write to our register
    logic [31:0]  rd_data_ff, nxt_rd_data;    // read answer
    logic         rd_hit_ff, nxt_rd_hit;      // read was ours
    logic [2:0]   sync1_ff;                   // first synchroniser stage
    logic [2:0]   sync2_ff;                   // second stage, safe to use
    logic         req_n_s;                    // synchronised bus request
    logic         mem_n_ff, nxt_mem_n;        // memory strobe
    logic [3:0]   byte_n_ff, nxt_byte_n;      // byte lanes
    logic [1:0]   half_n_ff, nxt_half_n;      // halfword lanes
    logic [1:0]   pin_o_ff, nxt_pin_o;        // shared pin levels
    logic [1:0]   pin_oe_ff, nxt_pin_oe;      // shared pin drive
    logic [1:0]   turn_cnt_ff, nxt_turn_cnt;  // turnaround cycles left
    logic         hold_ff, nxt_hold;          // address hold
    bicr_dma_st_t dma_st_ff, nxt_dma_st;      // dma arbitration
    logic         gnt_n_ff, nxt_gnt_n;        // grant pin

    // strobe use decode shared by three pins; high means pulse now
    function automatic logic use_now(input logic [1:0] mode,
                                     input logic       rd,
                                     input logic       wr);
        return (rd & mode[1]) | (wr & mode[0]);
    endfunction

    assign ctl    = bicr_decode(ctl_ff);
    assign wr_hit = cp0_wr_i && (cp0_wr_sel_i == `BICR_REG_NUM);

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // new settings act from the next edge; software allows slack
    always_comb begin
        nxt_ctl = ctl_ff;
        if (wr_hit && !ctl.lock) begin
            nxt_ctl = (cp0_wr_data_i & `BICR_WR_MASK) | `BICR_RES_HIGH_VAL;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl_ff <= `BICR_RESET_VAL;
        end else if (ce_i) begin
            ctl_ff <= nxt_ctl;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // one cycle latency; other register numbers answer zero
    always_comb begin
        nxt_rd_hit  = cp0_rd_i && (cp0_rd_sel_i == `BICR_REG_NUM);
        nxt_rd_data = 32'h0000_0000;
        if (nxt_rd_hit) begin
            nxt_rd_data = ctl_ff;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_ff <= 32'h0000_0000;
            rd_hit_ff  <= 1'b0;
        end else if (ce_i) begin
            rd_data_ff <= nxt_rd_data;
            rd_hit_ff  <= nxt_rd_hit;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // request idles high; branch pins idle low
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_ff <= 3'h4;
            sync2_ff <= 3'h4;
        end else if (ce_i) begin
            sync1_ff <= {bus_request_in_n_i, shared_branch_condition_pins_i};
            sync2_ff <= sync1_ff;
        end
    end
    assign req_n_s = sync2_ff[2];
    // ------------------------------------------------------------
    // strobes, lanes and shared pins
    // ------------------------------------------------------------
    // registered, so pins lag the cycle phase by one clock
    always_comb begin
        nxt_mem_n = ~use_now(ctl.mem_mode, cyc_i.rd, cyc_i.wr);
        nxt_byte_n = ~(cyc_i.byte_sel &
                       {4{cyc_i.wr | (cyc_i.rd & ctl.be_rd)}});
        nxt_half_n = ~(cyc_i.half_sel &
                       {2{cyc_i.wr | (cyc_i.rd & ctl.be16_rd)}});
        nxt_pin_o[1] = ~use_now(ctl.io_mode, cyc_i.rd, cyc_i.wr);
        nxt_pin_o[0] = ~use_now(ctl.ext_mode, cyc_i.rd, cyc_i.wr);
        if (ctl.br_in) begin
            nxt_pin_o  = 2'h3;
            nxt_pin_oe = 2'h0;
        end else begin
            nxt_pin_oe = 2'h3;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_n_ff  <= 1'b1;
            byte_n_ff <= 4'hf;
            half_n_ff <= 2'h3;
            pin_o_ff  <= 2'h3;
            pin_oe_ff <= 2'h0;
        end else if (ce_i) begin
            mem_n_ff  <= nxt_mem_n;
            byte_n_ff <= nxt_byte_n;
            half_n_ff <= nxt_half_n;
            pin_o_ff  <= nxt_pin_o;
            pin_oe_ff <= nxt_pin_oe;
        end
    end

    // ------------------------------------------------------------
    // bus turnaround
    // ------------------------------------------------------------
    // half cycle is inherent; this adds whole cycles only
    always_comb begin
        nxt_turn_cnt = turn_cnt_ff;
        if (rd_sampled_i) begin
            nxt_turn_cnt = ctl.turn;
        end else if (turn_cnt_ff != 2'h0) begin
            nxt_turn_cnt = turn_cnt_ff - 2'h1;
        end
        nxt_hold = (nxt_turn_cnt != 2'h0);
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            turn_cnt_ff <= 2'h0;
            hold_ff     <= 1'b0;
        end else if (ce_i) begin
            turn_cnt_ff <= nxt_turn_cnt;
            hold_ff     <= nxt_hold;
        end
    end

    // ------------------------------------------------------------
    // dma arbitration
    // ------------------------------------------------------------
    always_comb begin
        nxt_dma_st = dma_st_ff;
        unique case (dma_st_ff)
            BICR_DMA_IDLE: begin
                if (!req_n_s) begin
                    nxt_dma_st = BICR_DMA_GRANT;
                end
            end
            BICR_DMA_GRANT: begin
                if (req_n_s) begin
                    nxt_dma_st = BICR_DMA_IDLE;
                end else if (ctl.dma_pulse && reclaim_req_i) begin
                    nxt_dma_st = BICR_DMA_RECLAIM;
                end
            end
            BICR_DMA_RECLAIM: begin
                if (req_n_s) begin
                    nxt_dma_st = BICR_DMA_IDLE;
                end
            end
            default: begin
                nxt_dma_st = BICR_DMA_IDLE;
            end
        endcase
        nxt_gnt_n = (nxt_dma_st != BICR_DMA_GRANT);
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dma_st_ff <= BICR_DMA_IDLE;
            gnt_n_ff  <= 1'b1;
        end else if (ce_i) begin
            dma_st_ff <= nxt_dma_st;
            gnt_n_ff  <= nxt_gnt_n;
        end
    end

    // ------------------------------------------------------------
    // terminal count
    // ------------------------------------------------------------
    bicr_tc_gen u_tc (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .ce_i        (ce_i),
        .match_i     (count_match_i),
        .cmp_wr_i    (compare_wr_i),
        .hold_mode_i (ctl.tc_hold),
        .tc_n_o      (terminal_count_out_n_o)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign cp0_rd_data_o                    = rd_data_ff;
    assign cp0_rd_hit_o                     = rd_hit_ff;
    assign turnaround_hold_o                = hold_ff;
    assign memory_access_strobe_n_o         = mem_n_ff;
    assign byte_lane_selects_n_o            = byte_n_ff;
    assign halfword_lane_selects_n_o        = half_n_ff;
    assign shared_branch_condition_pins_o   = pin_o_ff;
    assign shared_branch_condition_pins_oe_o = pin_oe_ff;
    assign branch_condition_sync_o          = sync2_ff[1:0];
    assign bus_grant_out_n_o                = gnt_n_ff;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_lock;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (ctl.lock && wr_hit) |=> $stable(ctl_ff);
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked register changed on write");
    property p_res_high;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        ctl_ff[`BICR_RES_HIGH_BIT] == 1'b1;
    endproperty
    a_res_high: assert property (p_res_high)
        else $error("reserved high bit not one");
    property p_res_low;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (ctl_ff & ~(`BICR_WR_MASK | `BICR_RES_HIGH_VAL)) == 32'h0;
    endproperty
    a_res_low: assert property (p_res_low)
        else $error("reserved low bits not zero");
    property p_mem_wr;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (ce_i && cyc_i.wr && ctl.mem_mode[0]) |=> !memory_access_strobe_n_o;
    endproperty
    a_mem_wr: assert property (p_mem_wr)
        else $error("memory strobe missing on write");
    property p_pins_in;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (ce_i && ctl.br_in) |=> (shared_branch_condition_pins_oe_o == 2'h0);
    endproperty
    a_pins_in: assert property (p_pins_in)
        else $error("shared pins driven while inputs");
    property p_be_rd;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (ce_i && cyc_i.rd && !cyc_i.wr && !ctl.be_rd)
            |=> (byte_lane_selects_n_o == 4'hf);
    endproperty
    a_be_rd: assert property (p_be_rd)
        else $error("byte lanes asserted on read");
    sequence s_turn_max;
        ce_i && rd_sampled_i && (ctl.turn == 2'h3);
    endsequence
    property p_turn;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_turn_max ##1 (ce_i && !rd_sampled_i) |=> turnaround_hold_o;
    endproperty
    a_turn: assert property (p_turn)
        else $error("turnaround hold ended early");
    property p_dma_plain;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (ce_i && !bus_grant_out_n_o && !ctl.dma_pulse && !req_n_s)
            |=> !bus_grant_out_n_o;
    endproperty
    a_dma_plain: assert property (p_dma_plain)
        else $error("grant dropped during plain tenure");
    property p_reclaim;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (dma_st_ff == BICR_DMA_RECLAIM && !req_n_s) |=> bus_grant_out_n_o;
    endproperty
    a_reclaim: assert property (p_reclaim)
        else $error("grant reasserted before request dropped");
    property p_read;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (ce_i && cp0_rd_i && cp0_rd_sel_i == `BICR_REG_NUM)
            |=> (cp0_rd_data_o == $past(ctl_ff));
    endproperty
    a_read: assert property (p_read)
        else $error("read data differs from register");
endmodule

// ==== test/bicr_dma_model.sv ====
// dma master model: asks for the bus while told to, and
// leaves it until want_i drops once grant drops during a tenure
`timescale 1ns/1ps
module bicr_dma_model (
    input  wire logic clk_i,   // bench clock
    input  wire logic want_i,  // bench asks for a tenure
    input  wire logic gnt_n_i, // grant from the block
    output logic      req_n_o  // request pin, active low
);
    logic had;                 // grant seen this tenure
    // one process owns both; non-blocking on the rising edge keeps
    // the pin clear of the bench, which moves on falling edges
    initial begin
        req_n_o = 1'b1;
        had = 1'b0;
        forever @(posedge clk_i) begin
            had <= want_i && (had || !gnt_n_i);
            req_n_o <= !(want_i && !(had && gnt_n_i));
        end
    end
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the bus control register block
// assumes the design files and the dma model compile first
`timescale 1ns/1ps
module tb_top;
    import bicr_pkg::*;
    logic clk, rst_n, wr, rd, smp, match, cmp_wr, reclaim, want, ce;
    logic hit, hold, mem_n, gnt_n, req_n, tc_n;
    logic [4:0]  sel;
    logic [31:0] wd, rdata, s, v;
    logic [3:0]  be_n;
    logic [1:0]  hw_n, pin_o, pin_oe, bp, bsync;
    bicr_cyc_t   cyc;
    int          bad_count, n_checks, ticks;
    bicr_top dut (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
        .cp0_wr_i(wr), .cp0_wr_sel_i(sel), .cp0_wr_data_i(wd),
        .cp0_rd_i(rd), .cp0_rd_sel_i(sel), .cp0_rd_data_o(rdata),
        .cp0_rd_hit_o(hit), .cyc_i(cyc), .rd_sampled_i(smp),
        .turnaround_hold_o(hold), .memory_access_strobe_n_o(mem_n),
        .byte_lane_selects_n_o(be_n), .halfword_lane_selects_n_o(hw_n),
        .shared_branch_condition_pins_i(bp),
        .shared_branch_condition_pins_o(pin_o),
        .shared_branch_condition_pins_oe_o(pin_oe),
        .branch_condition_sync_o(bsync), .bus_request_in_n_i(req_n),
        .reclaim_req_i(reclaim), .bus_grant_out_n_o(gnt_n),
        .count_match_i(match), .compare_wr_i(cmp_wr),
        .terminal_count_out_n_o(tc_n));
    bicr_dma_model dma (.clk_i(clk), .want_i(want), .gnt_n_i(gnt_n),
        .req_n_o(req_n));
    // xorshift source, seeded at 6
    function automatic logic [31:0] nxt();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // what the register keeps of a written word
    function automatic logic [31:0] kept(input logic [31:0] d);
        return (d & 32'h8008_fdb3) | 32'h2000_0000;
    endfunction
    // active-low strobe level for a mode field and direction
    function automatic logic act_n(input logic [1:0] m, input logic r);
        return !(r ? m[1] : m[0]);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wreg(input logic [31:0] d);
        wr = 1'b1;
        wd = d;
        @(negedge clk) wr = 1'b0;
        repeat (10) @(negedge clk);
    endtask
    task automatic rreg(input logic [31:0] e);
        rd = 1'b1;
        @(negedge clk) rd = 1'b0;
        chk(rdata, e);
        chk(hit, 1'b1);
    endtask
    task automatic stop_test();
        $display("checks %0d bad %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard, far beyond the whole sequence
    always @(posedge clk) begin
        ticks++;
        if (ticks == 5000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        {rst_n, wr, rd, smp, match, cmp_wr, reclaim, want} = '0;
        {ce, bp} = 3'h4;
        sel = 5'h02;
        wd = '0;
        cyc = '0;
        s = 32'h6;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        rreg(32'h2008_f433);
        chk(pin_oe, 2'h0);
        chk(pin_o, 2'h3);
        repeat (4) begin
            v = nxt();
            bp = v[1:0];
            v = v & 32'h7fff_ffff;
            wreg(v);
            chk(bsync, bp);
            rreg(kept(v));
        end
        // frozen clock enable: the write must not land
        ce = 1'b0;
        wreg(32'h0);
        ce = 1'b1;
        rreg(kept(v));
        for (int m = 0; m < 4; m++) begin
            wreg({16'h0, {3{m[1:0]}}, 4'h0, m[0], m[0], 4'h0});
            v = nxt();
            cyc = {2'h1, v[5:0]};
            @(negedge clk) chk(mem_n, act_n(m[1:0], 0));
            chk(pin_o, {2{act_n(m[1:0], 0)}});
            chk(pin_oe, 2'h3);
            chk({be_n, hw_n}, 6'(~v[5:0]));
            cyc = {2'h2, v[5:0]};
            @(negedge clk) chk(mem_n, act_n(m[1:0], 1));
            chk(pin_o, {2{act_n(m[1:0], 1)}});
            chk({be_n, hw_n}, m[0] ? 6'(~v[5:0]) : 6'h3f);
            cyc = '0;
        end
        for (int n = 0; n < 4; n++) begin
            wreg(32'(n));
            smp = 1'b1;
            @(negedge clk) smp = 1'b0;
            v = 32'(hold);
            repeat (5) @(negedge clk) v += 32'(hold);
            chk(v, n);
        end
        for (int h = 0; h < 2; h++) begin
            wreg(32'(h) << 8);
            match = 1'b1;
            v = '0;
            repeat (4) @(negedge clk) {match, v} = {1'b0, v[30:0], tc_n};
            chk(v, h ? 32'h8 : 32'h9);
            cmp_wr = 1'b1;
            @(negedge clk) cmp_wr = 1'b0;
            @(negedge clk) chk(tc_n, 1'b1);
        end
        wreg(32'h80);
        want = 1'b1;
        v = '0;
        while (gnt_n !== 1'b0 && v < 10) @(negedge clk) v++;
        chk(gnt_n, 1'b0);
        reclaim = 1'b1;
        repeat (2) @(negedge clk) chk(gnt_n, 1'b1);
        repeat (6) @(negedge clk);
        chk({gnt_n, req_n}, 2'h3);
        {want, reclaim} = '0;
        wreg(32'h0);
        {want, reclaim} = 2'h3;
        repeat (8) @(negedge clk);
        chk(gnt_n, 1'b0);
        repeat (4) @(negedge clk) chk(gnt_n, 1'b0);
        {want, reclaim} = '0;
        v = nxt() | 32'h8000_0000;
        wreg(v);
        wreg(nxt());
        rreg(kept(v));
        stop_test();
    end
endmodule
